// [logic/sram_host.sv]
// Purpose: Host controller driving an async 128K x 16 static memory.
// Assumes: One request at a time; slow_grade_in held steady during each request.
// Notes:   Every pin changes only on clk_in edges, one phase per state.
//          Reads wait one extra cycle to cover the pin synchroniser.
`timescale 1ns/1ps
`include "sram_host_defines.svh"
// Operation
// RULE_01 - Wait address-to-data delay before sampling
// RULE_02 - Old data may linger after address change
// RULE_03 - Output drive low gives data in time
// RULE_04 - Byte select low gives lane data
// RULE_05 - Address set before write end long enough
// RULE_06 - Address stable across whole write
// RULE_07 - Write data set before end, held after
// RULE_08 - Byte selects lead write end enough
// RULE_09 - Write is chip select and strobe overlap
// RULE_10 - Data timed to terminating rising edge
// RULE_11 - Strobe write allows float plus setup
// RULE_12 - Strobe stays high during reads
// RULE_13 - Device floats pins while drive high
// RULE_14 - Joint rise leaves device outputs floating
// RULE_15 - Host never drives while device drives
// RULE_16 - Address valid before chip select falls
// RULE_17 - Device stores only selected lanes
// RULE_18 - Device drives only selected lanes
// RULE_19 - Device floats pins when not reading
// RULE_20 - Array is 131072 words of 16 bits
module sram_host (
   // Clock, reset and speed grade
   input  wire logic                       clk_in,
   input  wire logic                       nrst_in,
   input  wire logic                       slow_grade_in,
   // Request side
   input  wire logic                       req_valid_in,
   input  wire sram_host_pkg::req_t        req_in,
   output logic                            req_ready_out,
   output logic                            rd_valid_out,
   output logic [`DATA_W-1:0]              rd_data_out,
   // Memory pins
   output logic [`ADDR_W-1:0]              mem_addr_out,
   output sram_host_pkg::ctl_t             mem_ctl_out,
   input  wire logic [`DATA_W-1:0]         mem_data_in,
   output logic [`DATA_W-1:0]              mem_data_out,
   output logic                            mem_data_oe_n_out
);
   import sram_host_pkg::*;

   // Sequencer state.
   state_t               state_q;
   state_t               state_d;
   logic [`CNT_W-1:0]    cnt_q;
   logic [`CNT_W-1:0]    cnt_d;
   ctl_t                 ctl_q;
   ctl_t                 ctl_d;
   logic                 oe_n_q;
   logic                 oe_n_d;
   // Captured request and read result.
   req_t                 req_q;
   logic                 rdv_q;
   logic                 rdv_d;
   logic [`DATA_W-1:0]   rdat_q;
   logic [`DATA_W-1:0]   rdat_d;
   // Pin synchroniser.
   logic [`DATA_W-1:0]   sync1_q;
   logic [`DATA_W-1:0]   sync2_q;

   // Picks the wait count of the grade in use.
   function automatic logic [`CNT_W-1:0] grade_cnt(
      input logic              slow,
      input logic [`CNT_W-1:0] fast_cyc,
      input logic [`CNT_W-1:0] slow_cyc
   );
      grade_cnt = slow ? slow_cyc : fast_cyc;
   endfunction : grade_cnt

   // The pin word reaches the sampler two flops late, so the read wait
   // gets one extra count; a shorter wait would sample a floating bus.
   wire logic [`CNT_W-1:0]  rd_cnt = grade_cnt(slow_grade_in,
      `CNT_W'(`RD_CYC + `SYNC_EXTRA_CYC),
      `CNT_W'(`RD_CYC_SL + `SYNC_EXTRA_CYC));
   wire logic [`CNT_W-1:0]  wr_cnt = grade_cnt(slow_grade_in,
      `CNT_W'(`WR_CYC), `CNT_W'(`WR_CYC_SL));
   wire logic               idle     = (state_q == ST_IDLE);
   wire logic               cnt_done = (cnt_q == `CNT_W'(0));
   wire logic               take     = idle && req_valid_in;
   wire logic               sample   = (state_q == ST_RD) && cnt_done;
   wire logic [1:0]         lane_keep;
   wire logic [`DATA_W-1:0] lane_word;

   // Lane masking, one byte lane per pass.
   genvar lane;
   generate
      for (lane = 0; lane < 2; lane++) begin : g_lane
         // RULE_18 deselected lanes read zero
         assign lane_keep[lane] = ~req_q.lane_n[lane];
         assign lane_word[lane*8 +: 8] = lane_keep[lane] ?
                                         sync2_q[lane*8 +: 8] : 8'h00;
      end
   endgenerate

   // Outputs: every pin and data output comes straight from a flop.
   assign req_ready_out     = idle;
   assign rdv_d             = sample;
   assign rdat_d            = sample ? lane_word : rdat_q;
   assign rd_valid_out      = rdv_q;
   assign rd_data_out       = rdat_q;
   assign mem_addr_out      = req_q.addr;
   assign mem_ctl_out       = ctl_q;
   assign mem_data_out      = req_q.wdata;
   assign mem_data_oe_n_out = oe_n_q;

   // Next-state logic. The strobe falls with chip select, so the overlap
   // starts on one edge after the address has led by a full cycle.
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_done ? cnt_q : cnt_q - `CNT_W'(1);
      ctl_d   = ctl_q;
      oe_n_d  = oe_n_q;
      unique case (state_q)
         ST_IDLE: begin
            // RULE_16 address first
            if (req_valid_in) begin
               state_d = ST_SETUP;
            end
         end
         ST_SETUP: begin
            // Byte selects fall with chip select, so they lead the write
            // end by the whole strobe width.
            ctl_d.chip_sel_n       = 1'b0;
            ctl_d.upper_byte_sel_n = req_q.lane_n[1];
            ctl_d.lower_byte_sel_n = req_q.lane_n[0];
            if (req_q.wr) begin
               // RULE_12 strobe only here
               // RULE_09 overlap starts write
               ctl_d.write_strobe_n = 1'b0;
               // RULE_15 drive after float
               oe_n_d  = 1'b0;
               cnt_d   = wr_cnt;
               state_d = ST_WR;
            end else begin
               // RULE_03 drive enable low
               ctl_d.out_drive_n = 1'b0;
               cnt_d   = rd_cnt;
               state_d = ST_RD;
            end
         end
         ST_RD: begin
            // RULE_01 wait data delay
            if (cnt_done) begin
               state_d = ST_DONE;
            end
         end
         ST_WR: begin
            // RULE_05 RULE_08 RULE_11 hold strobe low
            if (cnt_done) begin
               // RULE_10 strobe rise ends write
               ctl_d.write_strobe_n = 1'b1;
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            // RULE_07 RULE_06 data and address held past end
            // Chip select rises one cycle after the strobe, so the write
            // always ends on the strobe with data still on the bus.
            ctl_d = '1;
            oe_n_d = 1'b1;
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // No reset: the chain only carries pin data, which is qualified later
   // by the sample strobe, so stale contents never reach an output.
   always_ff @(posedge clk_in) begin
      sync1_q <= mem_data_in;
      sync2_q <= sync1_q;
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         state_q <= ST_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // Control and drive-enable pins idle high, so a reset in mid-transfer ends it at the next clk_in edge.
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         ctl_q  <= '1;
         oe_n_q <= 1'b1;
      end else begin
         ctl_q  <= ctl_d;
         oe_n_q <= oe_n_d;
      end
   end

   // RULE_06 RULE_07 address and data held
   // The captured request stays on the pins until the next take.
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         req_q <= '0;
      end else if (take) begin
         req_q <= req_in;
      end
   end

   // A read result stands until the next read replaces it.
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         rdv_q  <= 1'b0;
         rdat_q <= '0;
      end else begin
         rdv_q  <= rdv_d;
         rdat_q <= rdat_d;
      end
   end
endmodule : sram_host

// [logic/sram_host_defines.svh]
// Purpose: Timing counts and widths for the async static memory host.
// Assumes: 40 MHz clock, 25 ns period.
// Notes:   Least times and longest times both round up to whole cycles.
`ifndef SRAM_HOST_DEFINES_SVH
`define SRAM_HOST_DEFINES_SVH
`define CLK_PERIOD_NS            25
`define ADDR_W                   17
`define DATA_W                   16
// Fast grade figures in ns; slow grade figures follow.
`define ADDR_TO_DATA_DELAY_NS    55
`define ADDR_TO_DATA_DELAY_SL_NS 70
`define DATA_HOLD_AFTER_ADDR_NS  10
`define ADDR_SETUP_TO_WRITE_END_NS    45
`define ADDR_SETUP_TO_WRITE_END_SL_NS 60
`define DATA_SETUP_TO_WRITE_END_NS    25
`define DATA_SETUP_TO_WRITE_END_SL_NS 30
`define BYTE_SEL_TO_WRITE_END_NS      50
`define BYTE_SEL_TO_WRITE_END_SL_NS   60
`define WRITE_STROBE_FLOAT_DELAY_NS    20
`define WRITE_STROBE_FLOAT_DELAY_SL_NS 25
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Read wait covers address-to-data, which bounds strobe-to-data too.
`define RD_CYC    `CEIL_CYC(`ADDR_TO_DATA_DELAY_NS)
`define RD_CYC_SL `CEIL_CYC(`ADDR_TO_DATA_DELAY_SL_NS)
// One more count so the word sampled two flops back lies in the window.
`define SYNC_EXTRA_CYC 1
// Strobe low time: byte select lead dominates, plus float delay.
`define WR_CYC    `CEIL_CYC(`BYTE_SEL_TO_WRITE_END_NS + \
                            `WRITE_STROBE_FLOAT_DELAY_NS)
`define WR_CYC_SL `CEIL_CYC(`BYTE_SEL_TO_WRITE_END_SL_NS + \
                            `WRITE_STROBE_FLOAT_DELAY_SL_NS)
`define CNT_W     3
`endif

// [logic/sram_host_pkg.sv]
// Purpose: Types for the async static memory host.
// Assumes: Constants come from sram_host_defines.svh.
// Notes:   None.
`include "sram_host_defines.svh"
package sram_host_pkg;
   typedef struct packed {
      logic                 wr;
      logic [`ADDR_W-1:0]   addr;
      logic [`DATA_W-1:0]   wdata;
      logic [1:0]           lane_n;
   } req_t;
   typedef struct packed {
      logic                 chip_sel_n;
      logic                 write_strobe_n;
      logic                 out_drive_n;
      logic                 upper_byte_sel_n;
      logic                 lower_byte_sel_n;
   } ctl_t;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_RD    = 3'b011,
      ST_WR    = 3'b101,
      ST_DONE  = 3'b010
   } state_t;
endpackage : sram_host_pkg

// [verif/sram_host_chk.sv]
// Purpose: Pin timing checks for the static memory host.
// Assumes: One clock domain; synchronous active low reset.
// Notes:   Bound to the host top module.
`timescale 1ns/1ps
`include "sram_host_defines.svh"
module sram_host_chk (
   input wire logic                clk_in,
   input wire logic                nrst_in,
   input wire logic                rd_valid_out,
   input wire logic [`ADDR_W-1:0]  mem_addr_out,
   input wire sram_host_pkg::ctl_t mem_ctl_out,
   input wire logic [`DATA_W-1:0]  mem_data_out,
   input wire logic                mem_data_oe_n_out
);
   import sram_host_pkg::*;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   wire ce_n = mem_ctl_out.chip_sel_n;
   wire we_n = mem_ctl_out.write_strobe_n;
   wire oe_n = mem_ctl_out.out_drive_n;
   chk_strobe_rd: assert property (!ce_n && !oe_n |-> we_n)
      else $error("strobe low during read");
   chk_no_clash: assert property (!mem_data_oe_n_out |-> oe_n)
      else $error("host drives while memory drives");
   chk_wr_overlap: assert property ($fell(we_n) |-> !ce_n)
      else $error("strobe fell without chip select");
   chk_addr_wr: assert property (!we_n |-> $stable(mem_addr_out))
      else $error("address moved during write");
   chk_addr_ce: assert property (
      $fell(ce_n) |-> $stable(mem_addr_out))
      else $error("address late at chip select");
   chk_strobe_len: assert property (
      $fell(we_n) |-> !we_n[*3] ##[1:3] we_n)
      else $error("strobe width wrong");
   chk_data_hold: assert property (
      $rose(we_n) |-> !ce_n && $stable(mem_data_out))
      else $error("write data not held");
   chk_wr_end: assert property (
      $rose(we_n) |=> ce_n && mem_data_oe_n_out)
      else $error("write not closed");
   chk_rd_time: assert property (
      $fell(oe_n) |-> ##[5:6] rd_valid_out)
      else $error("read answer out of window");
   cov_write: cover property ($fell(we_n));
   cov_read: cover property (rd_valid_out);
   cov_lane: cover property ($fell(oe_n) && mem_ctl_out.lower_byte_sel_n);
endmodule : sram_host_chk
bind sram_host sram_host_chk u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
   .rd_valid_out(rd_valid_out), .mem_addr_out(mem_addr_out),
   .mem_ctl_out(mem_ctl_out), .mem_data_out(mem_data_out),
   .mem_data_oe_n_out(mem_data_oe_n_out));

// [verif/sram_model.sv]
// Purpose: Behavioural static memory on the host's pins.
// Assumes: Host holds each read well past the access time.
// Notes:   Undriven lanes show a toggling pattern, never stale data.
`timescale 1ns/1ps
`include "sram_host_defines.svh"
module sram_model (
   input  wire logic                slow_in,
   input  wire logic [`ADDR_W-1:0]  addr_in,
   input  wire sram_host_pkg::ctl_t ctl_in,
   input  wire logic [`DATA_W-1:0]  host_data_in,
   input  wire logic                host_oe_n_in,
   output logic [`DATA_W-1:0]       bus_out
);
   import sram_host_pkg::*;
   logic [`DATA_W-1:0] mem [0:131071];
   logic [`DATA_W-1:0] flt = 16'h5a5a;
   logic               rd_ok = 1'b0;
   logic [`ADDR_W-1:0] addr_dly = '0;
   wire wr_act = !ctl_in.chip_sel_n && !ctl_in.write_strobe_n;
   wire rd_act = !ctl_in.chip_sel_n && ctl_in.write_strobe_n
                 && !ctl_in.out_drive_n;
   wire [1:0] on = {!ctl_in.upper_byte_sel_n, !ctl_in.lower_byte_sel_n}
                   & {2{rd_ok}};
   always #13 flt = ~flt;
   // old word lingers after the address moves
   always @(addr_in) addr_dly <= #(`DATA_HOLD_AFTER_ADDR_NS) addr_in;
   always @(rd_act or addr_in) begin
      if (!rd_act) rd_ok = 1'b0;
      else rd_ok <= #(`DATA_HOLD_AFTER_ADDR_NS) 1'b0;
      rd_ok <= #(slow_in ? `ADDR_TO_DATA_DELAY_SL_NS
                         : `ADDR_TO_DATA_DELAY_NS) rd_act;
   end
   // store selected lanes at write end
   always @(negedge wr_act) begin
      if (!ctl_in.lower_byte_sel_n) mem[addr_in][7:0] = host_data_in[7:0];
      if (!ctl_in.upper_byte_sel_n) mem[addr_in][15:8] = host_data_in[15:8];
   end
   assign bus_out = !host_oe_n_in ? host_data_in :
      {on[1] ? mem[addr_dly][15:8] : flt[15:8],
       on[0] ? mem[addr_dly][7:0] : flt[7:0]};
endmodule : sram_model

// [verif/testbench.sv]
// Purpose: Self-checking bench for the static memory host.
// Assumes: Memory model stands on the pins.
// Notes:   Inputs change 2 ns after each rising edge.
`timescale 1ns/1ps
`include "sram_host_defines.svh"
module testbench;
   import sram_host_pkg::*;
   logic clk_in = 1'b0, nrst_in = 1'b0, slow_grade_in = 1'b0;
   logic req_valid_in = 1'b0, req_ready_out, rd_valid_out, oe_n;
   req_t req_in = '0;
   ctl_t ctl;
   logic [`DATA_W-1:0] rd_data_out, bus, wdata;
   logic [`ADDR_W-1:0] addr;
   int n_mismatch = 0;
   int num_checks = 0;
   always #12.5 clk_in = ~clk_in;
   sram_host dut (.clk_in(clk_in), .nrst_in(nrst_in),
      .slow_grade_in(slow_grade_in), .req_valid_in(req_valid_in),
      .req_in(req_in), .req_ready_out(req_ready_out),
      .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
      .mem_addr_out(addr), .mem_ctl_out(ctl), .mem_data_in(bus),
      .mem_data_out(wdata), .mem_data_oe_n_out(oe_n));
   sram_model mem (.slow_in(slow_grade_in), .addr_in(addr), .ctl_in(ctl),
      .host_data_in(wdata), .host_oe_n_in(oe_n), .bus_out(bus));
   task check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task summarize;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task send(input logic w, input logic [16:0] a, input logic [15:0] d,
             input logic [1:0] l);
      int n;
      n = 0;
      @(posedge clk_in) #2;
      // Ready is decoded from state, so it is settled between edges.
      while (req_ready_out !== 1'b1 && n < 50) begin
         @(posedge clk_in) #2;
         n++;
      end
      if (n >= 50) n_mismatch++;
      req_in = {w, a, d, l};
      req_valid_in = 1'b1;
      @(posedge clk_in) #2;
      req_valid_in = 1'b0;
   endtask : send
   task read(input logic [16:0] a, input logic [1:0] l, input logic [15:0] e);
      int n;
      n = 0;
      send(1'b0, a, 16'h0000, l);
      while (rd_valid_out !== 1'b1 && n < 20) begin
         @(posedge clk_in) #2;
         n++;
      end
      check({15'h0000, rd_valid_out}, 16'h0001);
      check(rd_data_out, e);
   endtask : read
   task t_lanes;
      send(1'b1, 17'h1ffff, 16'h1234, 2'b00);
      send(1'b1, 17'h1ffff, 16'hab99, 2'b01);
      read(17'h1ffff, 2'b00, 16'hab34);
      read(17'h1ffff, 2'b10, 16'h0034);
      read(17'h1ffff, 2'b01, 16'hab00);
   endtask : t_lanes
   task t_slow;
      slow_grade_in = 1'b1;
      send(1'b1, 17'h00000, 16'h5aa5, 2'b00);
      read(17'h00000, 2'b00, 16'h5aa5);
      slow_grade_in = 1'b0;
   endtask : t_slow
   initial begin
      repeat (8) @(posedge clk_in);
      #2 check({9'h000, rd_valid_out, req_ready_out, ctl}, 16'h003f);
      nrst_in = 1'b1;
      t_lanes;
      t_slow;
      summarize;
   end
   // The tests need about 65 cycles; this leaves wide margin.
   initial begin
      #20000;
      n_mismatch++;
      summarize;
   end
endmodule : testbench
